// [logic/abe_pkg.sv]
/*
 shared constants and types for the execute block: operation codes, flag positions,
 cycle counts, register offsets and the write-back carrier.
 assumes a single core clock and one instruction issued at a time.
*/
package abe_pkg;

   // ----------
   // widths and register offsets
   // ----------
   localparam int PC_W = 22;
   localparam logic [3:0] REG_FLAGS = 4'h0;
   localparam logic [3:0] REG_PC_EXT = 4'h1;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] PC_EXT_RESET = 8'h00;
   localparam logic [7:0] ALL_ONES = 8'hff;

   // ----------
   // flag bit positions in the status register
   // ----------
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;

   // ----------
   // cycle counts
   // ----------
   localparam logic [2:0] CYC_ALU = 3'h1;
   localparam logic [2:0] CYC_WORD = 3'h2;
   localparam logic [2:0] CYC_MUL = 3'h2;
   localparam logic [2:0] CYC_JUMP = 3'h2;
   localparam logic [2:0] CYC_CALL = 3'h4;
   localparam logic [2:0] CYC_SKIP_NONE = 3'h1;
   localparam logic [2:0] CYC_SKIP_ONE = 3'h2;
   localparam logic [2:0] CYC_SKIP_TWO = 3'h3;

   // ----------
   // operations
   // ----------
   typedef enum logic [4:0] {
      op_nop,
      op_sum_two_regs,
      op_sum_with_carry,
      op_word_plus_imm,
      op_reg_minus_reg,
      op_reg_minus_imm,
      op_reg_minus_reg_borrow,
      op_reg_minus_imm_borrow,
      op_word_minus_imm,
      op_and_regs,
      op_mask_with_imm,
      op_or_regs,
      op_merge_with_imm,
      op_xor_regs,
      op_set_bits_imm,
      op_clear_bits_imm,
      op_zero_sign_check,
      op_unsigned_product,
      op_signed_product,
      op_mixed_sign_product,
      op_frac_unsigned_product,
      op_frac_signed_product,
      op_frac_mixed_product,
      op_pointer_jump,
      op_extended_pointer_jump,
      op_pointer_call,
      op_extended_pointer_call,
      op_compare_skip_equal,
      op_reg_compare,
      op_reg_compare_borrow,
      op_imm_compare
   } abe_op_t;

   // ----------
   // carriers
   // ----------
   typedef struct packed {
      logic wr_lo_en;
      logic wr_hi_en;
      logic [4:0] wr_idx;
      logic [7:0] wr_lo;
      logic [7:0] wr_hi;
      logic pc_load;
      logic [PC_W-1:0] pc_value;
      logic push_en;
      logic [PC_W-1:0] push_addr;
   } abe_wb_t;

   typedef struct packed {
      logic [7:0] res;
      logic c;
      logic h;
      logic v;
   } abe_alu_t;

endpackage : abe_pkg

// [logic/abe_mul.sv]
/*
 registered 8x8 multiplier with signed, mixed and fractional forms.
 assumes operands are held valid in the cycle the product is wanted for capture.
*/
module abe_mul (
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic a_signed,
   input wire logic b_signed,
   input wire logic frac,
   output logic [15:0] product,
   output logic carry
);

   logic [15:0] next_product;
   logic next_carry;

   // ----------
   // product
   // ----------
   always_comb begin
      logic signed [8:0] ea;
      logic signed [8:0] eb;
      logic signed [17:0] full;
      ea = $signed({a_signed & a[7], a});
      eb = $signed({b_signed & b[7], b});
      full = ea * eb;
      // carry is taken from the raw product, before the fractional shift
      next_carry = full[15];
      next_product = frac ? {full[14:0], 1'b0} : full[15:0];
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         product <= 16'h0000;
         carry <= 1'b0;
      end else begin
         product <= next_product;
         carry <= next_carry;
      end
   end

endmodule : abe_mul

// [logic/abe_core.sv]
/*
 execute stage for arithmetic, logic, multiply, pointer jump/call and compare operations.
 assumes the register file presents operands beside start and applies the write-back
 and the program counter update in the cycle done is high.
*/
// Operation
// - add and add-with-carry, one cycle, write result, update Z C N V H
// - add immediate to register pair, two cycles, update Z C N V S
// - subtract register or constant, one cycle, store, update Z C N V H
// - subtract with borrow, register or constant, one cycle, update Z C N V H
// - subtract immediate from register pair, two cycles, update Z C N V S
// - and, or, masks and xor in one cycle, update only Z N V
// - set bits ors constant, clear bits ands with inverse, update Z N V
// - zero/sign check ands register with itself, one cycle, update Z N V
// - three integer products into R1:R0, two cycles, update only Z and C
// - fractional products shift left one before write, two cycles, Z and C
// - pointer jumps load PC from Z, extended form prepends extension register
// - pointer calls push return address, load PC, four cycles, flags kept
// - compare-skip-equal skips next instruction when equal, 1/2/3 cycles, no flags
// - compares subtract without storing, one cycle, update Z N V C H
module abe_core (
   input wire logic clock,
   input wire logic rst,
   input wire logic start,
   input wire abe_pkg::abe_op_t op,
   input wire logic [4:0] rd_idx,
   input wire logic [7:0] rd_val,
   input wire logic [7:0] rd_hi_val,
   input wire logic [7:0] rr_val,
   input wire logic [7:0] imm,
   input wire logic [15:0] z_ptr,
   input wire logic [abe_pkg::PC_W-1:0] pc,
   input wire logic skip_two_word,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic busy,
   output logic done,
   output abe_pkg::abe_wb_t wb,
   output logic [7:0] flags
);

   typedef enum {st_idle, st_wait} abe_state_t;

   abe_state_t state;
   abe_state_t next_state;
   logic [2:0] cnt;
   logic [2:0] next_cnt;
   logic next_busy;
   logic next_done;
   abe_pkg::abe_wb_t next_wb;
   abe_pkg::abe_wb_t pend;
   abe_pkg::abe_wb_t next_pend;
   logic [7:0] pend_flags;
   logic [7:0] next_pend_flags;
   logic pend_mul;
   logic next_pend_mul;
   logic [7:0] next_flags;
   logic [7:0] pc_ext;
   logic [7:0] next_pc_ext;
   logic [7:0] next_reg_rdata;

   abe_pkg::abe_wb_t calc;
   logic [7:0] calc_flags;
   logic [2:0] calc_cycles;
   logic calc_mul;
   logic mul_a_signed;
   logic mul_b_signed;
   logic mul_frac;
   logic [15:0] mul_product;
   logic mul_carry;

   // ----------
   // helpers
   // ----------
   function automatic abe_pkg::abe_alu_t add8(input logic [7:0] x, input logic [7:0] y,
                                              input logic ci);
      logic [8:0] s;
      logic [4:0] hs;
      abe_pkg::abe_alu_t r;
      s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
      hs = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
      r.res = s[7:0];
      r.c = s[8];
      r.h = hs[4];
      r.v = (x[7] == y[7]) && (s[7] != x[7]);
      return r;
   endfunction : add8

   // carry and half carry here mean borrow out of bit 7 and bit 3
   function automatic abe_pkg::abe_alu_t sub8(input logic [7:0] x, input logic [7:0] y,
                                              input logic ci);
      logic [8:0] s;
      logic [4:0] hs;
      abe_pkg::abe_alu_t r;
      s = {1'b0, x} - {1'b0, y} - {8'h00, ci};
      hs = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, ci};
      r.res = s[7:0];
      r.c = s[8];
      r.h = hs[4];
      r.v = (x[7] != y[7]) && (s[7] != x[7]);
      return r;
   endfunction : sub8

   function automatic logic [7:0] arith_flags(input logic [7:0] f, input abe_pkg::abe_alu_t r,
                                              input logic chain_z);
      logic [7:0] o;
      o = f;
      o[abe_pkg::FLAG_C] = r.c;
      o[abe_pkg::FLAG_H] = r.h;
      o[abe_pkg::FLAG_V] = r.v;
      o[abe_pkg::FLAG_N] = r.res[7];
      // borrow forms keep zero only if it already held, so multi-byte tests work
      o[abe_pkg::FLAG_Z] = (r.res == 8'h00) && (!chain_z || f[abe_pkg::FLAG_Z]);
      return o;
   endfunction : arith_flags

   function automatic logic [7:0] logic_flags(input logic [7:0] f, input logic [7:0] res);
      logic [7:0] o;
      o = f;
      o[abe_pkg::FLAG_V] = 1'b0;
      o[abe_pkg::FLAG_N] = res[7];
      o[abe_pkg::FLAG_Z] = (res == 8'h00);
      return o;
   endfunction : logic_flags

   function automatic logic [7:0] word_flags(input logic [7:0] f, input logic [16:0] w,
                                             input logic hi7, input logic is_sub);
      logic [7:0] o;
      logic v;
      o = f;
      v = is_sub ? (hi7 && !w[15]) : (!hi7 && w[15]);
      o[abe_pkg::FLAG_C] = w[16];
      o[abe_pkg::FLAG_V] = v;
      o[abe_pkg::FLAG_N] = w[15];
      o[abe_pkg::FLAG_S] = w[15] ^ v;
      o[abe_pkg::FLAG_Z] = (w[15:0] == 16'h0000);
      return o;
   endfunction : word_flags

   // ----------
   // multiplier
   // ----------
   assign mul_a_signed = (op == abe_pkg::op_signed_product) ||
                         (op == abe_pkg::op_mixed_sign_product) ||
                         (op == abe_pkg::op_frac_signed_product) ||
                         (op == abe_pkg::op_frac_mixed_product);
   assign mul_b_signed = (op == abe_pkg::op_signed_product) ||
                         (op == abe_pkg::op_frac_signed_product);
   assign mul_frac = (op == abe_pkg::op_frac_unsigned_product) ||
                     (op == abe_pkg::op_frac_signed_product) ||
                     (op == abe_pkg::op_frac_mixed_product);

   abe_mul u_mul (
      .clock(clock),
      .rst(rst),
      .a(rd_val),
      .b(rr_val),
      .a_signed(mul_a_signed),
      .b_signed(mul_b_signed),
      .frac(mul_frac),
      .product(mul_product),
      .carry(mul_carry)
   );

   // ----------
   // operation decode and result
   // ----------
   always_comb begin
      abe_pkg::abe_alu_t r;
      logic [16:0] w;
      logic [7:0] lres;
      logic [23:0] tgt;
      r = '0;
      w = 17'h00000;
      lres = 8'h00;
      tgt = {pc_ext, z_ptr};
      calc = '0;
      calc.wr_idx = rd_idx;
      calc_flags = flags;
      calc_cycles = abe_pkg::CYC_ALU;
      calc_mul = 1'b0;
      case (op)
         abe_pkg::op_sum_two_regs, abe_pkg::op_sum_with_carry: begin
            r = add8(rd_val, rr_val,
                     (op == abe_pkg::op_sum_with_carry) && flags[abe_pkg::FLAG_C]);
            calc.wr_lo_en = 1'b1;
            calc.wr_lo = r.res;
            calc_flags = arith_flags(flags, r, 1'b0);
         end
         abe_pkg::op_reg_minus_reg, abe_pkg::op_reg_minus_imm: begin
            r = sub8(rd_val, (op == abe_pkg::op_reg_minus_imm) ? imm : rr_val, 1'b0);
            calc.wr_lo_en = 1'b1;
            calc.wr_lo = r.res;
            calc_flags = arith_flags(flags, r, 1'b0);
         end
         abe_pkg::op_reg_minus_reg_borrow, abe_pkg::op_reg_minus_imm_borrow: begin
            r = sub8(rd_val, (op == abe_pkg::op_reg_minus_imm_borrow) ? imm : rr_val,
                     flags[abe_pkg::FLAG_C]);
            calc.wr_lo_en = 1'b1;
            calc.wr_lo = r.res;
            calc_flags = arith_flags(flags, r, 1'b1);
         end
         abe_pkg::op_reg_compare, abe_pkg::op_imm_compare, abe_pkg::op_reg_compare_borrow: begin
            r = sub8(rd_val, (op == abe_pkg::op_imm_compare) ? imm : rr_val,
                     (op == abe_pkg::op_reg_compare_borrow) && flags[abe_pkg::FLAG_C]);
            calc_flags = arith_flags(flags, r, op == abe_pkg::op_reg_compare_borrow);
         end
         abe_pkg::op_word_plus_imm, abe_pkg::op_word_minus_imm: begin
            if (op == abe_pkg::op_word_plus_imm) begin
               w = {1'b0, rd_hi_val, rd_val} + {9'h000, imm};
            end else begin
               w = {1'b0, rd_hi_val, rd_val} - {9'h000, imm};
            end
            calc.wr_lo_en = 1'b1;
            calc.wr_hi_en = 1'b1;
            calc.wr_lo = w[7:0];
            calc.wr_hi = w[15:8];
            calc_flags = word_flags(flags, w, rd_hi_val[7],
                                    op == abe_pkg::op_word_minus_imm);
            calc_cycles = abe_pkg::CYC_WORD;
         end
         abe_pkg::op_and_regs, abe_pkg::op_mask_with_imm, abe_pkg::op_or_regs,
         abe_pkg::op_merge_with_imm, abe_pkg::op_xor_regs, abe_pkg::op_set_bits_imm,
         abe_pkg::op_clear_bits_imm, abe_pkg::op_zero_sign_check: begin
            case (op)
               abe_pkg::op_and_regs: lres = rd_val & rr_val;
               abe_pkg::op_mask_with_imm: lres = rd_val & imm;
               abe_pkg::op_or_regs: lres = rd_val | rr_val;
               abe_pkg::op_merge_with_imm: lres = rd_val | imm;
               abe_pkg::op_xor_regs: lres = rd_val ^ rr_val;
               abe_pkg::op_set_bits_imm: lres = rd_val | imm;
               abe_pkg::op_clear_bits_imm: lres = rd_val & (abe_pkg::ALL_ONES - imm);
               default: lres = rd_val & rd_val;
            endcase
            // the check form only sets flags, the register keeps its value anyway
            calc.wr_lo_en = (op != abe_pkg::op_zero_sign_check);
            calc.wr_lo = lres;
            calc_flags = logic_flags(flags, lres);
         end
         abe_pkg::op_unsigned_product, abe_pkg::op_signed_product,
         abe_pkg::op_mixed_sign_product, abe_pkg::op_frac_unsigned_product,
         abe_pkg::op_frac_signed_product, abe_pkg::op_frac_mixed_product: begin
            calc.wr_idx = 5'h00;
            calc.wr_lo_en = 1'b1;
            calc.wr_hi_en = 1'b1;
            calc_cycles = abe_pkg::CYC_MUL;
            calc_mul = 1'b1;
         end
         abe_pkg::op_pointer_jump, abe_pkg::op_extended_pointer_jump: begin
            calc.pc_load = 1'b1;
            calc.pc_value = (op == abe_pkg::op_extended_pointer_jump) ?
                            tgt[abe_pkg::PC_W-1:0] :
                            abe_pkg::PC_W'({8'h00, z_ptr});
            calc_cycles = abe_pkg::CYC_JUMP;
         end
         abe_pkg::op_pointer_call, abe_pkg::op_extended_pointer_call: begin
            calc.pc_load = 1'b1;
            calc.pc_value = (op == abe_pkg::op_extended_pointer_call) ?
                            tgt[abe_pkg::PC_W-1:0] :
                            abe_pkg::PC_W'({8'h00, z_ptr});
            calc.push_en = 1'b1;
            calc.push_addr = pc + abe_pkg::PC_W'(1);
            calc_cycles = abe_pkg::CYC_CALL;
         end
         abe_pkg::op_compare_skip_equal: begin
            if (rd_val == rr_val) begin
               calc.pc_load = 1'b1;
               calc.pc_value = pc + (skip_two_word ? abe_pkg::PC_W'(3) :
                                                     abe_pkg::PC_W'(2));
               calc_cycles = skip_two_word ? abe_pkg::CYC_SKIP_TWO :
                                             abe_pkg::CYC_SKIP_ONE;
            end else begin
               calc_cycles = abe_pkg::CYC_SKIP_NONE;
            end
         end
         default: begin
            calc_flags = flags;
         end
      endcase
   end

   // ----------
   // sequencing, flags and register port
   // ----------
   always_comb begin
      logic [7:0] mf;
      mf = pend_flags;
      next_state = state;
      next_cnt = cnt;
      next_busy = busy;
      next_done = 1'b0;
      next_wb = '0;
      next_pend = pend;
      next_pend_flags = pend_flags;
      next_pend_mul = pend_mul;
      next_flags = flags;
      next_pc_ext = pc_ext;
      next_reg_rdata = 8'h00;
      if (reg_wr && (reg_addr == abe_pkg::REG_FLAGS)) begin
         next_flags = reg_wdata;
      end
      if (reg_wr && (reg_addr == abe_pkg::REG_PC_EXT)) begin
         next_pc_ext = reg_wdata;
      end
      if (reg_rd) begin
         case (reg_addr)
            abe_pkg::REG_FLAGS: next_reg_rdata = flags;
            abe_pkg::REG_PC_EXT: next_reg_rdata = pc_ext;
            default: next_reg_rdata = 8'h00;
         endcase
      end
      case (state)
         st_idle: begin
            if (start && (op != abe_pkg::op_nop)) begin
               if (calc_cycles == abe_pkg::CYC_ALU) begin
                  // an operation completing beats a software write to the flags
                  next_done = 1'b1;
                  next_wb = calc;
                  next_flags = calc_flags;
               end else begin
                  next_state = st_wait;
                  next_cnt = calc_cycles - 3'h1;
                  next_busy = 1'b1;
                  next_pend = calc;
                  next_pend_flags = calc_flags;
                  next_pend_mul = calc_mul;
               end
            end
         end
         st_wait: begin
            next_cnt = cnt - 3'h1;
            if (cnt == 3'h1) begin
               next_state = st_idle;
               next_busy = 1'b0;
               next_done = 1'b1;
               next_wb = pend;
               if (pend_mul) begin
                  // products read the live flags so only Z and C move
                  mf = flags;
                  mf[abe_pkg::FLAG_C] = mul_carry;
                  mf[abe_pkg::FLAG_Z] = (mul_product == 16'h0000);
                  next_wb.wr_lo = mul_product[7:0];
                  next_wb.wr_hi = mul_product[15:8];
               end
               next_flags = mf;
            end
         end
         default: begin
            next_state = st_idle;
            next_busy = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state <= st_idle;
         cnt <= 3'h0;
         busy <= 1'b0;
         done <= 1'b0;
         wb <= '0;
         pend <= '0;
         pend_flags <= abe_pkg::FLAGS_RESET;
         pend_mul <= 1'b0;
         flags <= abe_pkg::FLAGS_RESET;
         pc_ext <= abe_pkg::PC_EXT_RESET;
         reg_rdata <= 8'h00;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         busy <= next_busy;
         done <= next_done;
         wb <= next_wb;
         pend <= next_pend;
         pend_flags <= next_pend_flags;
         pend_mul <= next_pend_mul;
         flags <= next_flags;
         pc_ext <= next_pc_ext;
         reg_rdata <= next_reg_rdata;
      end
   end

endmodule : abe_core

// [sim/abe_core_checker.sv]
/*
 concurrent checks on the execute block ports, bound to every abe_core.
 assumes pc and z_ptr stay put while an operation is in flight.
*/
module abe_core_checker (
   input wire logic clock,
   input wire logic rst,
   input wire logic start,
   input wire abe_pkg::abe_op_t op,
   input wire logic [4:0] rd_idx,
   input wire logic [7:0] rd_val,
   input wire logic [7:0] rr_val,
   input wire logic [15:0] z_ptr,
   input wire logic [abe_pkg::PC_W-1:0] pc,
   input wire logic skip_two_word,
   input wire logic reg_wr,
   input wire logic busy,
   input wire logic done,
   input wire abe_pkg::abe_wb_t wb,
   input wire logic [7:0] flags
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   logic go;
   logic cse;
   // a flags write on the issue edge would blur the kept-flag checks
   assign go = start && !busy && !reg_wr;
   assign cse = go && op == abe_pkg::op_compare_skip_equal;
   // ----------
   // properties
   // ----------
   sequence s_two;
      busy && !done ##1 done && !busy;
   endsequence
   property p_word;
      go && op inside {abe_pkg::op_word_plus_imm, abe_pkg::op_word_minus_imm}
      |=> s_two ##0 (wb.wr_hi_en && wb.wr_idx == $past(rd_idx, 2));
   endproperty
   property p_mul;
      go && op inside {[abe_pkg::op_unsigned_product:abe_pkg::op_frac_mixed_product]}
      |=> s_two ##0 (wb.wr_idx == 5'h00 && wb.wr_lo_en && wb.wr_hi_en);
   endproperty
   property p_logic;
      go && op inside {[abe_pkg::op_and_regs:abe_pkg::op_zero_sign_check]}
      |=> done && flags[3] == 1'b0 && ((flags ^ $past(flags)) & 8'h31) == 8'h00;
   endproperty
   property p_jump;
      go && op == abe_pkg::op_pointer_jump
      |=> s_two ##0 (wb.pc_load && wb.pc_value == {6'h00, $past(z_ptr, 2)});
   endproperty
   property p_call;
      go && op inside {abe_pkg::op_pointer_call, abe_pkg::op_extended_pointer_call}
      |=> busy [*3] ##1 (done && wb.push_en && wb.push_addr == $past(pc, 4) + 22'h000001);
   endproperty
   property p_skip_ne;
      cse && rd_val != rr_val |=> done && !wb.pc_load && !wb.wr_lo_en;
   endproperty
   property p_skip_eq;
      cse && rd_val == rr_val && !skip_two_word
      |=> s_two ##0 (wb.pc_load && wb.pc_value == $past(pc, 2) + 22'h000002);
   endproperty
   property p_cmp;
      go && op inside {[abe_pkg::op_reg_compare:abe_pkg::op_imm_compare]}
      |=> done && !wb.wr_lo_en && ((flags ^ $past(flags)) & 8'h10) == 8'h00;
   endproperty
   a_word: assert property (p_word) else $error("word op timing or pair wrong");
   a_mul: assert property (p_mul) else $error("product timing or pair wrong");
   a_logic: assert property (p_logic) else $error("logic op flags wrong");
   a_jump: assert property (p_jump) else $error("pointer jump target wrong");
   a_call: assert property (p_call) else $error("call timing or push wrong");
   a_skip_ne: assert property (p_skip_ne) else $error("unequal skip moved pc");
   a_skip_eq: assert property (p_skip_eq) else $error("equal skip target wrong");
   a_cmp: assert property (p_cmp) else $error("compare wrote or touched S");
endmodule : abe_core_checker

bind abe_core abe_core_checker chk_u (.clock, .rst, .start, .op, .rd_idx, .rd_val, .rr_val,
   .z_ptr, .pc, .skip_two_word, .reg_wr, .busy, .done, .wb, .flags);

// [sim/abe_rf_model.sv]
/*
 register file and program counter that sit beside the execute block.
 assumes write-back and pc load are taken at the edge where done is high.
*/
module abe_rf_model (
   input wire logic clock,
   input wire logic done,
   input wire abe_pkg::abe_wb_t wb,
   input wire logic [4:0] ri,
   output logic [15:0] q,
   output logic [abe_pkg::PC_W-1:0] pc_q
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] rf [32];
   always_ff @(posedge clock) begin
      if (done && wb.wr_lo_en) begin
         rf[wb.wr_idx] <= wb.wr_lo;
      end
      if (done && wb.wr_hi_en) begin
         rf[wb.wr_idx + 5'h01] <= wb.wr_hi;
      end
      if (done && wb.pc_load) begin
         pc_q <= wb.pc_value;
      end
   end
   assign q = {rf[ri + 5'h01], rf[ri]};
endmodule : abe_rf_model

// [sim/alu_branch_execute_tb.sv]
/*
 self-checking bench: a table of single operations, then jumps, calls, skips, reset.
 assumes the register file model commits write-back one edge after done.
*/
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module alu_branch_execute_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [4:0] op; // operation code
      logic [31:0] i; // rd, rd high, rr and imm, flags before
      logic [1:0] we;
      logic [23:0] o; // result pair, flags after
   } abe_row_t;
   localparam abe_row_t rows [26] = '{
      '{5'h01, 32'h0f000100, 2'h1, 24'h001020},
      '{5'h01, 32'h80008000, 2'h1, 24'h00000b},
      '{5'h02, 32'h7f000001, 2'h1, 24'h00802c},
      '{5'h04, 32'h00000100, 2'h1, 24'h00ff25},
      '{5'h05, 32'h10001000, 2'h1, 24'h000002},
      '{5'h06, 32'h05000510, 2'h1, 24'h000010},
      '{5'h07, 32'h05000503, 2'h1, 24'h00ff25},
      '{5'h03, 32'hff7f0120, 2'h3, 24'h80002c},
      '{5'h08, 32'h00000100, 2'h3, 24'hffff15},
      '{5'h09, 32'hff008000, 2'h1, 24'h008004},
      '{5'h0a, 32'hf0000f29, 2'h1, 24'h000023},
      '{5'h0b, 32'h4000013f, 2'h1, 24'h004131},
      '{5'h0c, 32'h00000000, 2'h1, 24'h000002},
      '{5'h0d, 32'ha500a508, 2'h1, 24'h000002},
      '{5'h0e, 32'h00008000, 2'h1, 24'h008004},
      '{5'h0f, 32'hff007f01, 2'h1, 24'h008005},
      '{5'h10, 32'h80000000, 2'h0, 24'h000004},
      '{5'h11, 32'hff00ff2c, 2'h3, 24'hfe012d},
      '{5'h12, 32'hff00ff01, 2'h3, 24'h000100},
      '{5'h13, 32'hff000200, 2'h3, 24'hfffe01},
      '{5'h14, 32'h80008002, 2'h3, 24'h800000},
      '{5'h15, 32'hff000100, 2'h3, 24'hfffe01},
      '{5'h16, 32'h80000200, 2'h3, 24'hfe0001},
      '{5'h1c, 32'h10002000, 2'h0, 24'h000005},
      '{5'h1d, 32'h01000003, 2'h0, 24'h000002},
      '{5'h1e, 32'h80000100, 2'h0, 24'h000028}};
   localparam logic [4:0] jops [4] = '{5'h18, 5'h17, 5'h1a, 5'h19};
   logic clock, rst, start, skip_two_word, reg_wr, reg_rd, busy, done;
   abe_pkg::abe_op_t op;
   abe_pkg::abe_wb_t wb;
   logic [4:0] rd_idx, ri;
   logic [7:0] rd_val, rd_hi_val, rr_val, imm, reg_wdata, reg_rdata, flags, v;
   logic [3:0] reg_addr;
   logic [15:0] z_ptr, q;
   logic [abe_pkg::PC_W-1:0] pc, pc_q;
   int miscompares = 0;
   int n_checks = 0;
   int n;
   abe_core dut_u (.clock, .rst, .start, .op, .rd_idx, .rd_val, .rd_hi_val, .rr_val, .imm,
      .z_ptr, .pc, .skip_two_word, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .busy, .done, .wb, .flags);
   abe_rf_model model_u (.clock, .done, .wb, .ri, .q, .pc_q);
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd
   // issues one operation and counts cycles until done
   task automatic go(input logic [4:0] o, input logic [31:0] x, output int c);
      @(posedge clock);
      start <= 1'b1;
      op <= abe_pkg::abe_op_t'(o);
      {rd_val, rd_hi_val, rr_val} <= x[31:8];
      imm <= x[15:8];
      @(posedge clock);
      start <= 1'b0;
      c = 1;
      #1;
      while (done !== 1'b1 && c < 9) begin
         @(posedge clock);
         #1;
         c++;
      end
   endtask : go
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   initial begin
      repeat (20000) @(posedge clock);
      miscompares++;
      wrap_up();
   end
   initial begin
      {rst, start, skip_two_word, reg_wr, reg_rd} = 5'h10;
      {rd_val, rd_hi_val, rr_val, imm, reg_wdata, reg_addr} = 44'h0;
      op = abe_pkg::op_nop;
      rd_idx = 5'h10;
      ri = 5'h10;
      z_ptr = 16'h1234;
      pc = 22'h000100;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      rd(4'h0, v);
      `CHK("flags reset", 8'h00, v)
      wr(4'h7, 8'h55);
      rd(4'h7, v);
      `CHK("unmapped read", 8'h00, v)
      wr(4'h1, 8'h3c);
      rd(4'h1, v);
      `CHK("extension reg", 8'h3c, v)
      $display("register port test done");
      foreach (rows[k]) begin
         wr(4'h0, rows[k].i[7:0]);
         go(rows[k].op, rows[k].i, n);
         `CHK("cycles", (rows[k].we == 2'h3) ? 2 : 1, n)
         `CHK("flags", rows[k].o[7:0], flags)
         `CHK("write enables", rows[k].we, {wb.wr_hi_en, wb.wr_lo_en})
         ri = (rows[k].we == 2'h3 && rows[k].op > 5'h08) ? 5'h00 : 5'h10;
         @(posedge clock);
         #1;
         if (rows[k].we[0]) `CHK("low byte", rows[k].o[15:8], q[7:0])
         if (rows[k].we[1]) `CHK("high byte", rows[k].o[23:16], q[15:8])
         $display("row %0d done", k);
      end
      for (int j = 0; j < 4; j++) begin
         wr(4'h0, 8'h3f);
         go(jops[j], 32'h0, n);
         `CHK("jump cycles", (j < 2) ? 2 : 4, n)
         if (j > 1) `CHK("push", 22'h000101, wb.push_addr)
         @(posedge clock);
         #1;
         `CHK("target", j[0] ? 22'h001234 : 22'h3c1234, pc_q)
         `CHK("flags kept", 8'h3f, flags)
         $display("jump %0d done", j);
      end
      for (int i = 0; i < 3; i++) begin
         skip_two_word <= (i == 2);
         go(abe_pkg::op_compare_skip_equal, {(i == 0) ? 8'h01 : 8'h05, 24'h000500}, n);
         `CHK("skip cycles", i + 1, n)
         `CHK("skip load", i != 0, wb.pc_load)
         @(posedge clock);
         #1;
         if (i > 0) `CHK("skip target", 22'h000101 + i, pc_q)
         `CHK("skip flags", 8'h3f, flags)
         $display("skip %0d done", i);
      end
      @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      rd(4'h0, v);
      `CHK("flags after reset", 8'h00, v)
      $display("second reset test done");
      wrap_up();
   end
endmodule : alu_branch_execute_tb
